// *** verilog/rscp_cfg.svh ***
`ifndef RSCP_CFG_SVH
`define RSCP_CFG_SVH
`define RSCP_CLK_HZ 25000000
`define RSCP_BAUD 9600
`define RSCP_BIT_CYC (`RSCP_CLK_HZ / `RSCP_BAUD)
`define RSCP_LOCK_MS 70
`define RSCP_LOCK_CYC (`RSCP_LOCK_MS * (`RSCP_CLK_HZ / 1000))
`define RSCP_WIN_MS 3600
`define RSCP_WIN_CYC (`RSCP_WIN_MS * (`RSCP_CLK_HZ / 1000))
`define RSCP_FIFO_DEPTH 16
`define RSCP_FIFO_WIDTH 8
`define RSCP_B_DIVERT 8'h02
`define RSCP_B_ATTN 8'h05
`define RSCP_B_ACK 8'h06
`define RSCP_B_INIT 8'h49
`define RSCP_B_CHAN 8'h4c
`define RSCP_B_PDOWN 8'h50
`define RSCP_B_RXM 8'h52
`define RSCP_B_RPT 8'h53
`define RSCP_B_TXM 8'h54
`define RSCP_ST_OFF 8'h00
`define RSCP_ST_RX 8'h02
`define RSCP_ST_TX 8'h04
`define RSCP_ST_RX_UNLK 8'h22
`define RSCP_ST_TX_UNLK 8'h32
`endif

// *** verilog/rscp_pkg.sv ***
package rscp_pkg;
  typedef enum logic [6:0] {
    D_IDLE = 7'h01,
    D_ACK = 7'h02,
    D_CMD = 7'h04,
    D_CH1 = 7'h08,
    D_CH2 = 7'h10,
    D_RPT = 7'h20,
    D_DIV = 7'h40
  } rscp_dev_state_t;
  typedef enum logic [8:0] {
    H_IDLE = 9'h001,
    H_ATT = 9'h002,
    H_WACK = 9'h004,
    H_CMD = 9'h008,
    H_CH1 = 9'h010,
    H_CH2 = 9'h020,
    H_WRPT = 9'h040,
    H_DONE = 9'h080,
    H_DIV = 9'h100
  } rscp_host_state_t;
  typedef enum logic [1:0] {
    M_OFF = 2'h0,
    M_RX = 2'h1,
    M_TX = 2'h2
  } rscp_mode_t;
endpackage : rscp_pkg

// *** verilog/rscp_if.sv ***
`timescale 1ns/1ps
interface rscp_if;
  logic setup_serial_in;
  logic status_serial_out;
  logic serial_activity_n;
  logic transmit_enable_n;
  logic receive_enable_n;
  modport dev (
    input setup_serial_in,
    input transmit_enable_n,
    input receive_enable_n,
    output status_serial_out,
    output serial_activity_n
  );
  modport host (
    output setup_serial_in,
    output transmit_enable_n,
    output receive_enable_n,
    input status_serial_out,
    input serial_activity_n
  );
endinterface : rscp_if

// *** verilog/rscp_device.sv ***
// Notes on behaviour
// - Lock timeout low after 70 ms unlocked.
// - Byte 02H diverts later bytes to pass-through.
// - 9600 baud, 8 data, 1 stop, no parity.
// - Start bit is a high-to-low line edge.
// - Attention 05H is answered with 06H.
// - Host sends the command within 3.6 s.
// - 49H loads both channels from the switches.
// - 4CH takes transmit then receive channel bytes.
// - Channel bytes use the switch channel encoding.
// - 50H disables transmitter and receiver.
// - 54H enables the transmitter.
// - 52H enables the receiver.
// - 53H sends echo, tx, rx channel, status.
// - Status codes 00, 02, 04, 22, 32.
// - Low transmit enable turns transmitter on.
// - Modulation data limited to 10 kbps.
// - Transmit wins; receive alone; both high off.
// - Activity output low while status data sent; tx_ready drives it, so it is low while sending.
// - Ready output low while tx or rx on and synthesiser locked.
`timescale 1ns/1ps
`include "rscp_cfg.svh"

module rscp_uart_rx #(
  parameter int BIT_CYC = `RSCP_BIT_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Serial line and received byte
  input wire logic line_in,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  localparam int CW = $clog2(BIT_CYC);
  logic s1, s2, prev, busy, next_busy, next_valid;
  logic [CW-1:0] cnt, next_cnt;
  logic [3:0] bitn, next_bitn;
  logic [7:0] sh, next_sh, next_data;
  always_comb begin
    next_busy = busy;
    next_cnt = cnt;
    next_bitn = bitn;
    next_sh = sh;
    next_valid = 1'b0;
    next_data = byte_data;
    if (!busy) begin
      if (prev && !s2) begin
        next_busy = 1'b1;
        next_cnt = CW'(BIT_CYC / 2);
        next_bitn = 4'h0;
      end
    end else if (cnt == '0) begin
      next_cnt = CW'(BIT_CYC - 1);
      next_bitn = bitn + 4'h1;
      if (bitn == 4'h0 && s2) begin
        next_busy = 1'b0;
      end else if (bitn == 4'h9) begin
        next_busy = 1'b0;
        next_valid = s2;
        next_data = sh;
      end else if (bitn != 4'h0) begin
        next_sh = {s2, sh[7:1]};
      end
    end else begin
      next_cnt = cnt - 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      prev <= 1'b1;
      busy <= 1'b0;
      cnt <= '0;
      bitn <= 4'h0;
      sh <= 8'h00;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
    end else begin
      s1 <= line_in;
      s2 <= s1;
      prev <= s2;
      busy <= next_busy;
      cnt <= next_cnt;
      bitn <= next_bitn;
      sh <= next_sh;
      byte_valid <= next_valid;
      byte_data <= next_data;
    end
  end
endmodule : rscp_uart_rx

module rscp_uart_tx #(
  parameter int BIT_CYC = `RSCP_BIT_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Byte to send
  input wire logic send_valid,
  input wire logic [7:0] send_data,
  output logic send_ready,
  // Serial line
  output logic line_out
);
  localparam int CW = $clog2(BIT_CYC);
  logic busy, next_busy;
  logic [CW-1:0] cnt, next_cnt;
  logic [3:0] bitn, next_bitn;
  logic [9:0] sh, next_sh;
  assign send_ready = !busy;
  assign line_out = sh[0];
  always_comb begin
    next_busy = busy;
    next_cnt = cnt;
    next_bitn = bitn;
    next_sh = sh;
    if (!busy) begin
      if (send_valid) begin
        next_sh = {1'b1, send_data, 1'b0};
        next_busy = 1'b1;
        next_cnt = CW'(BIT_CYC - 1);
        next_bitn = 4'h0;
      end
    end else if (cnt == '0) begin
      next_cnt = CW'(BIT_CYC - 1);
      next_bitn = bitn + 4'h1;
      next_sh = {1'b1, sh[9:1]};
      if (bitn == 4'h9) begin
        next_busy = 1'b0;
      end
    end else begin
      next_cnt = cnt - 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      cnt <= '0;
      bitn <= 4'h0;
      sh <= 10'h3ff;
    end else begin
      busy <= next_busy;
      cnt <= next_cnt;
      bitn <= next_bitn;
      sh <= next_sh;
    end
  end
endmodule : rscp_uart_tx

module rscp_fifo #(
  parameter int WIDTH = `RSCP_FIFO_WIDTH,
  parameter int DEPTH = `RSCP_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr, rd, next_wr, next_rd;
  assign in_ready = (wr[AW] == rd[AW]) || (wr[AW-1:0] != rd[AW-1:0]);
  assign out_valid = (wr != rd);
  assign out_data = mem[rd[AW-1:0]];
  always_comb begin
    next_wr = wr + (AW + 1)'(in_valid && in_ready);
    next_rd = rd + (AW + 1)'(out_valid && out_ready);
  end
  always_ff @(posedge clk_sys) begin
    if (in_valid && in_ready) begin
      mem[wr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr <= '0;
      rd <= '0;
    end else begin
      wr <= next_wr;
      rd <= next_rd;
    end
  end
endmodule : rscp_fifo

module rscp_device import rscp_pkg::*; #(
  parameter int LOCK_CYC = `RSCP_LOCK_CYC,
  parameter int WIN_CYC = `RSCP_WIN_CYC,
  parameter int BIT_CYC = `RSCP_BIT_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Serial link
  rscp_if.dev link,
  // Radio side
  input wire logic [7:0] switch_channel,
  input wire logic synth_lock,
  output logic tx_on,
  output logic rx_on,
  output logic [7:0] tx_channel,
  output logic [7:0] rx_channel,
  output logic lock_timeout_n,
  output logic synth_ready_n,
  // Pass-through byte stream
  output logic pass_valid,
  output logic [7:0] pass_data,
  input wire logic pass_ready,
  output logic pass_overrun
);
  localparam int WW = $clog2(WIN_CYC);
  localparam int LW = $clog2(LOCK_CYC);
  rscp_dev_state_t state, next_state;
  rscp_mode_t mode, next_mode;
  logic te_s1, te_s2, re_s1, re_s2, lk_s1, lk_s2;
  logic [7:0] sw_s1, sw_s2;
  logic rx_valid, tx_valid, tx_ready, f_in_ready, next_overrun;
  logic [7:0] rx_data, tx_data, status_byte, next_tx_ch, next_rx_ch;
  logic [WW-1:0] win_cnt, next_win_cnt;
  logic [1:0] idx, next_idx, init_cnt, next_init_cnt;
  logic [LW-1:0] lock_cnt, next_lock_cnt;
  logic next_tx_on, next_rx_on, next_timeout_n, next_ready_n, win_end;

  rscp_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .clk_sys(clk_sys), .reset_n(reset_n), .line_in(link.setup_serial_in),
    .byte_valid(rx_valid), .byte_data(rx_data)
  );
  rscp_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk_sys(clk_sys), .reset_n(reset_n), .send_valid(tx_valid),
    .send_data(tx_data), .send_ready(tx_ready), .line_out(link.status_serial_out)
  );
  rscp_fifo #(.WIDTH(8), .DEPTH(`RSCP_FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys), .reset_n(reset_n), .in_valid(rx_valid && state == D_DIV),
    .in_data(rx_data), .in_ready(f_in_ready), .out_valid(pass_valid),
    .out_data(pass_data), .out_ready(pass_ready)
  );
  assign link.serial_activity_n = tx_ready;
  assign win_end = (win_cnt == WW'(WIN_CYC - 1));

  always_comb begin
    if (tx_on) begin
      status_byte = lk_s2 ? `RSCP_ST_TX : `RSCP_ST_TX_UNLK;
    end else if (rx_on) begin
      status_byte = lk_s2 ? `RSCP_ST_RX : `RSCP_ST_RX_UNLK;
    end else begin
      status_byte = `RSCP_ST_OFF;
    end
  end

  always_comb begin
    next_state = state;
    next_mode = mode;
    next_tx_ch = tx_channel;
    next_rx_ch = rx_channel;
    next_win_cnt = win_cnt;
    next_idx = idx;
    next_init_cnt = init_cnt;
    next_overrun = pass_overrun;
    tx_valid = 1'b0;
    tx_data = `RSCP_B_ACK;
    if (init_cnt != 2'h3) begin
      next_init_cnt = init_cnt + 2'h1;
      if (init_cnt == 2'h2) begin
        next_tx_ch = sw_s2;
        next_rx_ch = sw_s2;
      end
    end
    case (state)
      D_IDLE: begin
        if (rx_valid && rx_data == `RSCP_B_ATTN) begin
          next_state = D_ACK;
        end else if (rx_valid && rx_data == `RSCP_B_DIVERT) begin
          next_state = D_DIV;
        end
      end
      D_ACK: begin
        tx_valid = 1'b1;
        if (tx_ready) begin
          next_state = D_CMD;
          next_win_cnt = '0;
        end
      end
      D_CMD: begin
        if (rx_valid) begin
          next_state = D_IDLE;
          case (rx_data)
            `RSCP_B_INIT: begin
              next_tx_ch = sw_s2;
              next_rx_ch = sw_s2;
            end
            `RSCP_B_CHAN: begin
              next_state = D_CH1;
              next_win_cnt = '0;
            end
            `RSCP_B_PDOWN: next_mode = M_OFF;
            `RSCP_B_TXM: next_mode = M_TX;
            `RSCP_B_RXM: next_mode = M_RX;
            `RSCP_B_RPT: begin
              next_state = D_RPT;
              next_idx = 2'h0;
            end
            `RSCP_B_DIVERT: next_state = D_DIV;
            default: next_state = D_IDLE;
          endcase
        end else if (win_end) begin
          next_state = D_IDLE;
        end else begin
          next_win_cnt = win_cnt + 1'b1;
        end
      end
      D_CH1: begin
        if (rx_valid) begin
          next_tx_ch = rx_data;
          next_state = D_CH2;
          next_win_cnt = '0;
        end else if (win_end) begin
          next_state = D_IDLE;
        end else begin
          next_win_cnt = win_cnt + 1'b1;
        end
      end
      D_CH2: begin
        if (rx_valid) begin
          next_rx_ch = rx_data;
          next_state = D_IDLE;
        end else if (win_end) begin
          next_state = D_IDLE;
        end else begin
          next_win_cnt = win_cnt + 1'b1;
        end
      end
      D_RPT: begin
        tx_valid = 1'b1;
        case (idx)
          2'h0: tx_data = `RSCP_B_RPT;
          2'h1: tx_data = tx_channel;
          2'h2: tx_data = rx_channel;
          default: tx_data = status_byte;
        endcase
        if (tx_ready) begin
          next_idx = idx + 2'h1;
          if (idx == 2'h3) begin
            next_state = D_IDLE;
          end
        end
      end
      D_DIV: begin
        if (rx_valid && !f_in_ready) begin
          next_overrun = 1'b1;
        end
      end
      default: next_state = D_IDLE;
    endcase
  end

  always_comb begin
    next_tx_on = !te_s2 || mode == M_TX;
    next_rx_on = !next_tx_on && (!re_s2 || mode == M_RX);
    next_lock_cnt = lock_cnt;
    next_timeout_n = lock_timeout_n;
    next_ready_n = !((tx_on || rx_on) && lk_s2);
    if ({next_tx_on, next_rx_on} != {tx_on, rx_on} || lk_s2 || !(tx_on || rx_on)) begin
      next_lock_cnt = '0;
      next_timeout_n = 1'b1;
    end else if (lock_cnt == LW'(LOCK_CYC - 1)) begin
      next_timeout_n = 1'b0;
    end else begin
      next_lock_cnt = lock_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      te_s1 <= 1'b1;
      te_s2 <= 1'b1;
      re_s1 <= 1'b1;
      re_s2 <= 1'b1;
      lk_s1 <= 1'b0;
      lk_s2 <= 1'b0;
      sw_s1 <= 8'h00;
      sw_s2 <= 8'h00;
      state <= D_IDLE;
      mode <= M_OFF;
      tx_channel <= 8'h00;
      rx_channel <= 8'h00;
      win_cnt <= '0;
      idx <= 2'h0;
      init_cnt <= 2'h0;
      pass_overrun <= 1'b0;
      tx_on <= 1'b0;
      rx_on <= 1'b0;
      lock_cnt <= '0;
      lock_timeout_n <= 1'b1;
      synth_ready_n <= 1'b1;
    end else begin
      te_s1 <= link.transmit_enable_n;
      te_s2 <= te_s1;
      re_s1 <= link.receive_enable_n;
      re_s2 <= re_s1;
      lk_s1 <= synth_lock;
      lk_s2 <= lk_s1;
      sw_s1 <= switch_channel;
      sw_s2 <= sw_s1;
      state <= next_state;
      mode <= next_mode;
      tx_channel <= next_tx_ch;
      rx_channel <= next_rx_ch;
      win_cnt <= next_win_cnt;
      idx <= next_idx;
      init_cnt <= next_init_cnt;
      pass_overrun <= next_overrun;
      tx_on <= next_tx_on;
      rx_on <= next_rx_on;
      lock_cnt <= next_lock_cnt;
      lock_timeout_n <= next_timeout_n;
      synth_ready_n <= next_ready_n;
    end
  end
endmodule : rscp_device

// *** verilog/rscp_host.sv ***
`timescale 1ns/1ps
`include "rscp_cfg.svh"

module rscp_host import rscp_pkg::*; #(
  parameter int WIN_CYC = `RSCP_WIN_CYC,
  parameter int BIT_CYC = `RSCP_BIT_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Serial link
  rscp_if.host link,
  // Mode pin requests
  input wire logic tx_enable,
  input wire logic rx_enable,
  // Request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_code,
  input wire logic [7:0] req_tx_ch,
  input wire logic [7:0] req_rx_ch,
  // Response
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [31:0] rsp_report,
  output logic pass_mode
);
  localparam int WW = $clog2(WIN_CYC);
  rscp_host_state_t state, next_state;
  logic [7:0] code, tch, rch, next_code, next_tch, next_rch, rx_data, tx_data;
  logic [31:0] next_report;
  logic [WW-1:0] tmo, next_tmo;
  logic [1:0] cnt, next_cnt;
  logic rx_valid, tx_valid, tx_ready, next_rsp_valid, next_rsp_ok, tmo_end;

  rscp_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .clk_sys(clk_sys), .reset_n(reset_n), .line_in(link.status_serial_out),
    .byte_valid(rx_valid), .byte_data(rx_data)
  );
  rscp_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk_sys(clk_sys), .reset_n(reset_n), .send_valid(tx_valid),
    .send_data(tx_data), .send_ready(tx_ready), .line_out(link.setup_serial_in)
  );
  assign tmo_end = (tmo == WW'(WIN_CYC - 1));
  assign pass_mode = (state == H_DIV);
  assign req_ready = (state == H_IDLE) || (state == H_DIV && tx_ready);

  always_comb begin
    next_state = state;
    next_code = code;
    next_tch = tch;
    next_rch = rch;
    next_report = rsp_report;
    next_tmo = tmo + 1'b1;
    next_cnt = cnt;
    next_rsp_valid = 1'b0;
    next_rsp_ok = rsp_ok;
    tx_valid = 1'b0;
    tx_data = code;
    case (state)
      H_IDLE: begin
        if (req_valid) begin
          next_code = req_code;
          next_tch = req_tx_ch;
          next_rch = req_rx_ch;
          next_state = (req_code == `RSCP_B_DIVERT) ? H_CMD : H_ATT;
        end
      end
      H_ATT: begin
        tx_valid = 1'b1;
        tx_data = `RSCP_B_ATTN;
        if (tx_ready) begin
          next_state = H_WACK;
          next_tmo = '0;
        end
      end
      H_WACK: begin
        if (rx_valid || tmo_end) begin
          next_state = (rx_valid && rx_data == `RSCP_B_ACK) ? H_CMD : H_IDLE;
          next_rsp_valid = !(rx_valid && rx_data == `RSCP_B_ACK);
          next_rsp_ok = 1'b0;
        end
      end
      H_CMD: begin
        tx_valid = 1'b1;
        if (tx_ready) begin
          next_tmo = '0;
          next_cnt = 2'h0;
          if (code == `RSCP_B_CHAN) begin
            next_state = H_CH1;
          end else if (code == `RSCP_B_RPT) begin
            next_state = H_WRPT;
          end else begin
            next_state = H_DONE;
          end
        end
      end
      H_CH1: begin
        tx_valid = 1'b1;
        tx_data = tch;
        if (tx_ready) begin
          next_state = H_CH2;
        end
      end
      H_CH2: begin
        tx_valid = 1'b1;
        tx_data = rch;
        if (tx_ready) begin
          next_state = H_DONE;
        end
      end
      H_WRPT: begin
        if (rx_valid) begin
          next_report = {rsp_report[23:0], rx_data};
          next_cnt = cnt + 2'h1;
          if (cnt == 2'h3) begin
            next_state = H_IDLE;
            next_rsp_valid = 1'b1;
            next_rsp_ok = (rsp_report[23:16] == `RSCP_B_RPT);
          end
        end else if (tmo_end) begin
          next_state = H_IDLE;
          next_rsp_valid = 1'b1;
          next_rsp_ok = 1'b0;
        end
      end
      H_DONE: begin
        if (tx_ready) begin
          next_rsp_valid = 1'b1;
          next_rsp_ok = 1'b1;
          next_state = (code == `RSCP_B_DIVERT) ? H_DIV : H_IDLE;
        end
      end
      H_DIV: begin
        tx_valid = req_valid;
        tx_data = req_code;
      end
      default: next_state = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= H_IDLE;
      code <= 8'h00;
      tch <= 8'h00;
      rch <= 8'h00;
      rsp_report <= 32'h0000_0000;
      tmo <= '0;
      cnt <= 2'h0;
      rsp_valid <= 1'b0;
      rsp_ok <= 1'b0;
      link.transmit_enable_n <= 1'b1;
      link.receive_enable_n <= 1'b1;
    end else begin
      state <= next_state;
      code <= next_code;
      tch <= next_tch;
      rch <= next_rch;
      rsp_report <= next_report;
      tmo <= next_tmo;
      cnt <= next_cnt;
      rsp_valid <= next_rsp_valid;
      rsp_ok <= next_rsp_ok;
      link.transmit_enable_n <= !tx_enable;
      link.receive_enable_n <= !rx_enable;
    end
  end
endmodule : rscp_host

// *** verification/rscp_link_checker.sv ***
`timescale 1ns/1ps
module rscp_frame_mon #(
  parameter int BIT_CYC = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Watched line and recovered frame
  input wire logic line,
  output logic [15:0] cnt,
  output logic [7:0] data
);
  localparam int HALF = BIT_CYC / 2;
  logic [15:0] next_cnt;
  logic [7:0] next_data;
  always_comb begin
    next_cnt = cnt;
    next_data = data;
    if (cnt != 16'h0) begin
      next_cnt = (cnt == 16'(10 * BIT_CYC - 1)) ? 16'h0 : cnt + 16'h1;
    end else if (!line) begin
      next_cnt = 16'h1;
    end
    if (cnt > 16'(HALF) && cnt < 16'(9 * BIT_CYC) && (int'(cnt) - HALF) % BIT_CYC == 0) begin
      next_data = {line, data[7:1]};
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 16'h0;
      data <= 8'h00;
    end else begin
      cnt <= next_cnt;
      data <= next_data;
    end
  end
endmodule : rscp_frame_mon

module rscp_link_checker #(
  parameter int BIT_CYC = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Link signals
  input wire logic setup_serial_in,
  input wire logic status_serial_out,
  input wire logic serial_activity_n,
  input wire logic transmit_enable_n,
  input wire logic receive_enable_n
);
  localparam int ACK_MAX = 2 * BIT_CYC;
  logic [15:0] d_cnt;
  logic [15:0] h_cnt;
  logic [7:0] d_data;
  logic [7:0] h_data;
  logic d_done;
  logic h_done;
  logic exp_valid;
  logic next_exp_valid;
  logic [7:0] exp_byte;
  logic [7:0] next_exp_byte;
  rscp_frame_mon #(.BIT_CYC(BIT_CYC)) i_dev_mon (.clk_sys(clk_sys), .reset_n(reset_n),
    .line(status_serial_out), .cnt(d_cnt), .data(d_data));
  rscp_frame_mon #(.BIT_CYC(BIT_CYC)) i_host_mon (.clk_sys(clk_sys), .reset_n(reset_n),
    .line(setup_serial_in), .cnt(h_cnt), .data(h_data));
  assign d_done = d_cnt == 16'(9 * BIT_CYC + BIT_CYC / 2);
  assign h_done = h_cnt == 16'(9 * BIT_CYC + BIT_CYC / 2);
  // Remembers which reply byte the device owes after an attention or report byte.
  always_comb begin
    next_exp_valid = d_done ? 1'b0 : exp_valid;
    next_exp_byte = exp_byte;
    if (h_done && (h_data == 8'h05 || h_data == 8'h53)) begin
      next_exp_valid = 1'b1;
      next_exp_byte = (h_data == 8'h05) ? 8'h06 : 8'h53;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      exp_valid <= 1'b0;
      exp_byte <= 8'h00;
    end else begin
      exp_valid <= next_exp_valid;
      exp_byte <= next_exp_byte;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_start_held;
    !status_serial_out [*8];
  endsequence
  sequence s_dev_start;
    $fell(status_serial_out);
  endsequence
  a_stop_dev_high: assert property (d_done |-> status_serial_out)
    else $error("device stop bit not high");
  a_stop_host_high: assert property (h_done |-> setup_serial_in)
    else $error("host stop bit not high");
  a_start_bit_held: assert property (s_dev_start |-> s_start_held)
    else $error("device start bit too short");
  a_reset_lines_idle: assert property ($rose(reset_n) |-> setup_serial_in && status_serial_out)
    else $error("serial lines not idle high after reset");
  a_activity_in_frame: assert property (d_cnt != 16'h0 && !d_done |-> !serial_activity_n)
    else $error("activity high during status frame");
  a_activity_idle_line: assert property (serial_activity_n |-> status_serial_out)
    else $error("status line low without activity");
  a_reply_starts: assert property (h_done && h_data == 8'h05 |-> ##[1:ACK_MAX] s_dev_start)
    else $error("no acknowledge after attention");
  a_reply_value: assert property (d_done && exp_valid |-> d_data == exp_byte)
    else $error("wrong reply byte");
  a_enables_reset_off: assert property ($rose(reset_n) |-> transmit_enable_n && receive_enable_n)
    else $error("mode enables active after reset");
endmodule : rscp_link_checker

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb;
  localparam int BIT = 16;
  localparam int LOCK = 200;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] switch_channel = 8'h0a;
  logic synth_lock = 1'b0;
  logic pass_ready = 1'b0;
  logic tx_enable = 1'b0;
  logic rx_enable = 1'b0;
  logic req_valid = 1'b0;
  logic [7:0] req_code = 8'h00;
  logic [7:0] req_tx_ch = 8'h00;
  logic [7:0] req_rx_ch = 8'h00;
  logic tx_on, rx_on, lock_timeout_n, synth_ready_n, pass_valid, pass_overrun;
  logic req_ready, rsp_valid, rsp_ok, pass_mode;
  logic [7:0] tx_channel, rx_channel, pass_data;
  logic [31:0] rsp_report;
  logic [7:0] codes [3] = '{8'h54, 8'h52, 8'h50};
  logic [7:0] st [6] = '{8'h32, 8'h22, 8'h00, 8'h04, 8'h02, 8'h00};
  int failures = 0;
  int checked = 0;
  rscp_if i_rscp_if ();
  rscp_device #(.LOCK_CYC(LOCK), .WIN_CYC(2000), .BIT_CYC(BIT)) i_rscp_device (
    .clk_sys(clk_sys), .reset_n(reset_n), .link(i_rscp_if.dev),
    .switch_channel(switch_channel), .synth_lock(synth_lock), .tx_on(tx_on), .rx_on(rx_on),
    .tx_channel(tx_channel), .rx_channel(rx_channel), .lock_timeout_n(lock_timeout_n),
    .synth_ready_n(synth_ready_n), .pass_valid(pass_valid), .pass_data(pass_data),
    .pass_ready(pass_ready), .pass_overrun(pass_overrun));
  rscp_host #(.WIN_CYC(2000), .BIT_CYC(BIT)) i_rscp_host (
    .clk_sys(clk_sys), .reset_n(reset_n), .link(i_rscp_if.host), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .req_valid(req_valid), .req_ready(req_ready), .req_code(req_code),
    .req_tx_ch(req_tx_ch), .req_rx_ch(req_rx_ch), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .rsp_report(rsp_report), .pass_mode(pass_mode));
  rscp_link_checker #(.BIT_CYC(BIT)) i_rscp_link_checker (
    .clk_sys(clk_sys), .reset_n(reset_n), .setup_serial_in(i_rscp_if.setup_serial_in),
    .status_serial_out(i_rscp_if.status_serial_out),
    .serial_activity_n(i_rscp_if.serial_activity_n),
    .transmit_enable_n(i_rscp_if.transmit_enable_n),
    .receive_enable_n(i_rscp_if.receive_enable_n));

  task automatic results();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick

  task automatic send(input logic [7:0] code, input logic [7:0] txc, input logic [7:0] rxc,
                      input bit wait_rsp);
    int n;
    n = 0;
    tick(1);
    while (req_ready !== 1'b1 && n < 9000) begin
      tick(1);
      n++;
    end
    req_code = code;
    req_tx_ch = txc;
    req_rx_ch = rxc;
    req_valid = 1'b1;
    tick(1);
    req_valid = 1'b0;
    while (wait_rsp && rsp_valid !== 1'b1 && n < 9000) begin
      tick(1);
      n++;
    end
    chk("handshake", 0, n >= 9000);
  endtask : send

  task automatic report(input logic [31:0] exp);
    send(8'h53, 8'h00, 8'h00, 1'b1);
    chk("rsp_ok", 1, rsp_ok);
    chk("report", exp, rsp_report);
  endtask : report

  task automatic t_chan();
    send(8'h4c, 8'h14, 8'h16, 1'b1);
    chk("tx_channel", 8'h14, tx_channel);
    chk("rx_channel", 8'h16, rx_channel);
    report(32'h53141600);
    switch_channel = 8'h1c;
    send(8'h49, 8'h00, 8'h00, 1'b1);
    report(32'h531c1c00);
    $display("test channels done");
  endtask : t_chan

  task automatic t_modes();
    for (int i = 0; i < 6; i++) begin
      synth_lock = (i > 2);
      send(codes[i % 3], 8'h00, 8'h00, 1'b1);
      tick(6);
      chk("tx_on", codes[i % 3] == 8'h54, tx_on);
      chk("rx_on", codes[i % 3] == 8'h52, rx_on);
      chk("synth_ready_n", !(i > 2 && i != 5), synth_ready_n);
      report({24'h531c1c, st[i]});
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_pins();
    tx_enable = 1'b1;
    rx_enable = 1'b1;
    synth_lock = 1'b0;
    tick(8);
    chk("tx_on", 1, tx_on);
    chk("rx_on", 0, rx_on);
    tx_enable = 1'b0;
    tick(8);
    chk("rx_on", 1, rx_on);
    tick(LOCK - 30);
    chk("lock_timeout_n", 1, lock_timeout_n);
    tick(40);
    chk("lock_timeout_n", 0, lock_timeout_n);
    synth_lock = 1'b1;
    tick(6);
    chk("lock_timeout_n", 1, lock_timeout_n);
    chk("synth_ready_n", 0, synth_ready_n);
    report(32'h531c1c02);
    rx_enable = 1'b0;
    tick(8);
    chk("rx_on", 0, rx_on);
    send(8'h77, 8'h00, 8'h00, 1'b1);
    report(32'h531c1c00);
    $display("test pins done");
  endtask : t_pins

  task automatic t_divert();
    int n;
    send(8'h02, 8'h00, 8'h00, 1'b1);
    chk("pass_mode", 1, pass_mode);
    for (int i = 0; i < 17; i++) begin
      send(8'h40 + 8'(i), 8'h00, 8'h00, 1'b0);
    end
    tick(12 * BIT);
    chk("pass_overrun", 1, pass_overrun);
    for (int i = 0; i < 16; i++) begin
      n = 0;
      while (pass_valid !== 1'b1 && n < 99) begin
        tick(1);
        n++;
      end
      chk("pass_data", 8'h40 + 8'(i), pass_data);
      pass_ready = 1'b1;
      tick(1);
      pass_ready = 1'b0;
      tick(1);
    end
    chk("pass_valid", 0, pass_valid);
    $display("test divert done");
  endtask : t_divert

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    tick(3);
    reset_n = 1'b1;
    tick(4);
    t_chan();
    t_modes();
    t_pins();
    t_divert();
    results();
  end

  initial begin
    #4000000;
    failures++;
    results();
  end
endmodule : tb
